/* File: inc/rl_map.svh */
// constants for the remote/local interface-state block
// ----------------------------------------------------------------------
// ----------------------------------------------------------------------
`ifndef RL_MAP_SVH
`define RL_MAP_SVH
`define RL_ADDR_W      5
`define RL_ADDR_RESET  5'h16
`define RL_ADDR_MAX    5'h1E
`define RL_KEYS_W      8
`define RL_KEY_LOCAL   0
`define RL_RANGE_W     3
`define RL_VAL_W       24
`define RL_IFC_MIN_NS  100000
`define RL_CLK_NS      8
`define RL_IFC_CYCLES  ((`RL_IFC_MIN_NS + `RL_CLK_NS - 1) / `RL_CLK_NS)
`endif

/* File: inc/rl_pkg.sv */
// types for the remote/local interface-state block
package rl_pkg;
   typedef enum logic [1:0] {
      LOCS = 2'b00,
      REMS = 2'b01,
      RWLS = 2'b11
   } rl_state_t;

   typedef struct packed {
      logic ren;
      logic ifc;
      logic llo;
      logic gtl;
      logic mla;
      logic mta;
      logic unl;
      logic unt;
   } bus_evt_t;

   typedef struct packed {
      logic remote;
      logic talk;
      logic listen;
   } lamps_t;
endpackage

/* File: core/rl_control.sv */
// remote/local, lockout and talker/listener state for a bus instrument
`timescale 1ns/1ps
`default_nettype none
`include "rl_map.svh"

module rl_control (
   input  wire logic                     CLK,
   input  wire logic                     RSTN,
   input  wire rl_pkg::bus_evt_t         BUS_EVT,
   input  wire logic                     ADDR_WE,
   input  wire logic [`RL_ADDR_W-1:0]    ADDR_IN,
   output logic      [`RL_ADDR_W-1:0]    PRIMARY_ADDR,
   input  wire logic [`RL_KEYS_W-1:0]    PANEL_KEYS,
   output logic      [`RL_KEYS_W-1:0]    PANEL_KEYS_GATED,
   output rl_pkg::lamps_t                LAMPS,
   output logic                          LOCKOUT,
   output logic                          TALK_ACTIVE,
   input  wire logic                     AUTORANGE_EN,
   input  wire logic [`RL_VAL_W-1:0]     RAW_MAG,
   input  wire logic [`RL_VAL_W-1:0]     RANGE_LIMIT_0,
   input  wire logic [`RL_VAL_W-1:0]     RANGE_LIMIT_1,
   input  wire logic [`RL_VAL_W-1:0]     RANGE_LIMIT_2,
   input  wire logic [`RL_VAL_W-1:0]     RANGE_LIMIT_3,
   input  wire logic [`RL_RANGE_W-1:0]   MANUAL_RANGE,
   output logic      [`RL_RANGE_W-1:0]   RANGE_SEL,
   input  wire logic                     REL_EN,
   input  wire logic                     ZERO_CORR_EN,
   input  wire logic signed [`RL_VAL_W-1:0] RAW_IN,
   input  wire logic signed [`RL_VAL_W-1:0] ZERO_OFFSET,
   input  wire logic signed [`RL_VAL_W-1:0] BASELINE,
   output logic signed [`RL_VAL_W-1:0]   READING
);

   // ----------------------------------------------------------------------
   // remote/local state
   // ----------------------------------------------------------------------
   rl_pkg::rl_state_t state;
   rl_pkg::rl_state_t next_state;
   logic              local_key;
   logic              is_remote;

   assign local_key = PANEL_KEYS[`RL_KEY_LOCAL];
   assign is_remote = (state != rl_pkg::LOCS);

   always_comb begin
      next_state = state;
      case (state)
         rl_pkg::LOCS: begin
            // ren alone does nothing; needs listen addressing under ren
            if (BUS_EVT.ren && BUS_EVT.mla) begin
               // an armed lockout survives go-to-local, so re-entry is locked again
               next_state = (BUS_EVT.llo || LOCKOUT) ? rl_pkg::RWLS : rl_pkg::REMS;
            end
         end
         rl_pkg::REMS: begin
            if (!BUS_EVT.ren) begin
               next_state = rl_pkg::LOCS;
            end else if (BUS_EVT.gtl) begin
               next_state = rl_pkg::LOCS;
            end else if (BUS_EVT.llo) begin
               next_state = rl_pkg::RWLS;
            end else if (local_key && !LOCKOUT) begin
               next_state = rl_pkg::LOCS;
            end
         end
         rl_pkg::RWLS: begin
            if (!BUS_EVT.ren) begin
               next_state = rl_pkg::LOCS;
            end else if (BUS_EVT.gtl) begin
               next_state = rl_pkg::LOCS;
            end
         end
         default: next_state = rl_pkg::LOCS;
      endcase
   end

   always_ff @(posedge CLK or negedge RSTN) begin
      if (!RSTN) begin
         state <= rl_pkg::LOCS;
      end else begin
         state <= next_state;
      end
   end

   // ----------------------------------------------------------------------
   // lockout latch
   // ----------------------------------------------------------------------
   // kept apart from the state so a go-to-local leaves lockout armed
   always_ff @(posedge CLK or negedge RSTN) begin
      if (!RSTN) begin
         LOCKOUT <= 1'b0;
      end else if (!BUS_EVT.ren) begin
         LOCKOUT <= 1'b0;
      end else if (BUS_EVT.llo && (is_remote || BUS_EVT.mla)) begin
         LOCKOUT <= 1'b1;
      end
   end

   // re-entering remote with lockout armed lands straight in lockout
   logic lock_now;
   assign lock_now = (state == rl_pkg::RWLS);

   // ----------------------------------------------------------------------
   // talker / listener
   // ----------------------------------------------------------------------
   logic talker;
   logic listener;

   always_ff @(posedge CLK or negedge RSTN) begin
      if (!RSTN) begin
         talker <= 1'b0;
      end else if (BUS_EVT.ifc) begin
         talker <= 1'b0;
      end else if (BUS_EVT.mta) begin
         talker <= 1'b1;
      end else if (BUS_EVT.unt || BUS_EVT.mla) begin
         talker <= 1'b0;
      end
   end

   always_ff @(posedge CLK or negedge RSTN) begin
      if (!RSTN) begin
         listener <= 1'b0;
      end else if (BUS_EVT.ifc) begin
         listener <= 1'b0;
      end else if (BUS_EVT.mla) begin
         listener <= 1'b1;
      end else if (BUS_EVT.unl || BUS_EVT.mta) begin
         listener <= 1'b0;
      end
   end

   // ifc is shown as a level; 100 us minimum is the controller's duty
   assign TALK_ACTIVE = talker;

   // ----------------------------------------------------------------------
   // indicators and panel gating
   // ----------------------------------------------------------------------
   always_ff @(posedge CLK or negedge RSTN) begin
      if (!RSTN) begin
         LAMPS <= '0;
      end else begin
         LAMPS.remote <= (next_state != rl_pkg::LOCS);
         LAMPS.talk   <= talker && !BUS_EVT.ifc;
         LAMPS.listen <= listener && !BUS_EVT.ifc;
      end
   end

   always_ff @(posedge CLK or negedge RSTN) begin
      if (!RSTN) begin
         PANEL_KEYS_GATED <= '0;
      end else if (lock_now || LOCKOUT && is_remote) begin
         PANEL_KEYS_GATED <= '0;
      end else if (is_remote) begin
         PANEL_KEYS_GATED <= PANEL_KEYS & (`RL_KEYS_W'(1) << `RL_KEY_LOCAL);
      end else begin
         PANEL_KEYS_GATED <= PANEL_KEYS;
      end
   end

   // ----------------------------------------------------------------------
   // primary address
   // ----------------------------------------------------------------------
   always_ff @(posedge CLK or negedge RSTN) begin
      if (!RSTN) begin
         PRIMARY_ADDR <= `RL_ADDR_RESET;
      end else if (ADDR_WE && ADDR_IN <= `RL_ADDR_MAX) begin
         PRIMARY_ADDR <= ADDR_IN;
      end
   end

   // ----------------------------------------------------------------------
   // autorange and zero correction
   // ----------------------------------------------------------------------
   logic [`RL_RANGE_W-1:0] auto_range;

   // only the raw magnitude is compared; the baseline never enters
   always_comb begin
      if (RAW_MAG <= RANGE_LIMIT_0) begin
         auto_range = `RL_RANGE_W'(0);
      end else if (RAW_MAG <= RANGE_LIMIT_1) begin
         auto_range = `RL_RANGE_W'(1);
      end else if (RAW_MAG <= RANGE_LIMIT_2) begin
         auto_range = `RL_RANGE_W'(2);
      end else if (RAW_MAG <= RANGE_LIMIT_3) begin
         auto_range = `RL_RANGE_W'(3);
      end else begin
         auto_range = `RL_RANGE_W'(4);
      end
   end

   logic signed [`RL_VAL_W-1:0] corrected;
   assign corrected = ZERO_CORR_EN ? RAW_IN - ZERO_OFFSET : RAW_IN;

   always_ff @(posedge CLK or negedge RSTN) begin
      if (!RSTN) begin
         RANGE_SEL <= '0;
         READING   <= '0;
      end else begin
         RANGE_SEL <= AUTORANGE_EN ? auto_range : MANUAL_RANGE;
         READING   <= REL_EN ? corrected - BASELINE : corrected;
      end
   end

   // ----------------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------------
   a_ren_alone_local: assert property (@(posedge CLK) disable iff (!RSTN)
      (state == rl_pkg::LOCS && !BUS_EVT.mla) |=> state == rl_pkg::LOCS)
      else $error("entered remote without listen addressing");

   a_listen_enters_remote: assert property (@(posedge CLK) disable iff (!RSTN)
      (state == rl_pkg::LOCS && BUS_EVT.ren && BUS_EVT.mla) |=> is_remote)
      else $error("listen under ren did not enter remote");

   a_panel_gated_remote: assert property (@(posedge CLK) disable iff (!RSTN)
      is_remote |=> (PANEL_KEYS_GATED & ~(`RL_KEYS_W'(1) << `RL_KEY_LOCAL)) == '0)
      else $error("panel key passed while remote");

   a_local_key_return: assert property (@(posedge CLK) disable iff (!RSTN)
      (state == rl_pkg::REMS && BUS_EVT.ren && !BUS_EVT.gtl && !BUS_EVT.llo && local_key)
      |=> state == rl_pkg::LOCS)
      else $error("local key ignored without lockout");

   a_remote_lamp: assert property (@(posedge CLK) disable iff (!RSTN)
      ##1 LAMPS.remote == is_remote)
      else $error("remote lamp disagrees with state");

   a_ifc_idle: assert property (@(posedge CLK) disable iff (!RSTN)
      BUS_EVT.ifc |=> !talker && !listener && !LAMPS.talk && !LAMPS.listen)
      else $error("ifc did not idle talker and listener");

   a_lockout_holds: assert property (@(posedge CLK) disable iff (!RSTN)
      (LOCKOUT && BUS_EVT.ren) |=> LOCKOUT)
      else $error("lockout dropped while ren true");

   a_lock_blocks_local: assert property (@(posedge CLK) disable iff (!RSTN)
      (state == rl_pkg::RWLS && BUS_EVT.ren && !BUS_EVT.gtl) |=> state == rl_pkg::RWLS)
      else $error("left lockout without gtl or ren low");

   a_gtl_to_local: assert property (@(posedge CLK) disable iff (!RSTN)
      (is_remote && BUS_EVT.gtl) |=> state == rl_pkg::LOCS && !LAMPS.remote)
      else $error("gtl did not return to local");

   a_ren_drop_clears: assert property (@(posedge CLK) disable iff (!RSTN)
      !BUS_EVT.ren |=> !LOCKOUT && !is_remote)
      else $error("ren low did not clear remote");

   a_talk_in_local: assert property (@(posedge CLK) disable iff (!RSTN)
      (BUS_EVT.mta && !BUS_EVT.ifc) |=> TALK_ACTIVE)
      else $error("talker addressing refused");

   a_address_reset: assert property (@(posedge CLK)
      !RSTN |=> PRIMARY_ADDR == `RL_ADDR_RESET || RSTN)
      else $error("primary address not preset");

   // sampled reset is still low at the release edge, where registers hold reset values;
   // a plain RSTN term in an antecedent keeps the input-to-register checks off that edge

   a_relock_on_listen: assert property (@(posedge CLK) disable iff (!RSTN)
      (state == rl_pkg::LOCS && LOCKOUT && BUS_EVT.ren && BUS_EVT.mla)
      |=> state == rl_pkg::RWLS)
      else $error("armed lockout not restored on re-entry");

   a_lockout_no_keys: assert property (@(posedge CLK) disable iff (!RSTN)
      (LOCKOUT && is_remote) |=> PANEL_KEYS_GATED == '0)
      else $error("panel key passed under lockout");

   a_local_keys_pass: assert property (@(posedge CLK) disable iff (!RSTN)
      (RSTN && !is_remote) |=> PANEL_KEYS_GATED == $past(PANEL_KEYS))
      else $error("panel keys blocked in local");

   a_addr_refused: assert property (@(posedge CLK) disable iff (!RSTN)
      (RSTN && ADDR_WE && ADDR_IN > `RL_ADDR_MAX) |=> $stable(PRIMARY_ADDR))
      else $error("out of range address accepted");

   a_addr_written: assert property (@(posedge CLK) disable iff (!RSTN)
      (RSTN && ADDR_WE && ADDR_IN <= `RL_ADDR_MAX) |=> PRIMARY_ADDR == $past(ADDR_IN))
      else $error("valid address not stored");

   a_range_raw_only: assert property (@(posedge CLK) disable iff (!RSTN)
      (RSTN && AUTORANGE_EN && RAW_MAG <= RANGE_LIMIT_0) |=> RANGE_SEL == '0)
      else $error("autorange skipped the lowest range");

   // zero correction must leave the baseline untouched: an input equal to the zero offset shows minus baseline
   a_zero_raw_only: assert property (@(posedge CLK) disable iff (!RSTN)
      (RSTN && REL_EN && ZERO_CORR_EN && RAW_IN == ZERO_OFFSET)
      |=> READING == -$past(BASELINE))
      else $error("zero correction touched the baseline");

   a_talk_lamp_lit: assert property (@(posedge CLK) disable iff (!RSTN)
      (TALK_ACTIVE && !BUS_EVT.ifc) |=> LAMPS.talk)
      else $error("talk lamp dark while addressed");

   a_ren_low_dark: assert property (@(posedge CLK) disable iff (!RSTN)
      !BUS_EVT.ren |=> !LAMPS.remote)
      else $error("remote lamp lit with ren low");

endmodule
`default_nettype wire

/* File: testbench/bus_ctrl_model.sv */
// bus controller model driving the remote/local event lines
`timescale 1ns/1ps
`default_nettype none
`include "rl_map.svh"

module bus_ctrl_model (
   input  wire logic        clk,
   output rl_pkg::bus_evt_t evt
);
   // ----
   // line levels and command pulses
   // ----
   initial evt = '0;
   task set_ren(input logic v);
      @(posedge clk);
      evt.ren <= v;
   endtask
   // several commands may share one cycle
   task pulse(input logic [7:0] m);
      @(posedge clk);
      evt <= evt | m;
      @(posedge clk);
      evt <= evt & ~m;
   endtask
   // full minimum hold, no shortened clear
   task clear_bus;
      @(posedge clk);
      evt.ifc <= 1'b1;
      repeat (`RL_IFC_CYCLES) @(posedge clk);
      evt.ifc <= 1'b0;
   endtask
endmodule
`default_nettype wire

/* File: testbench/tb_gpib_remote_local_control.sv */
// self-checking bench for the remote/local interface-state block
`timescale 1ns/1ps
`default_nettype none
`include "rl_map.svh"

module tb_gpib_remote_local_control;
   // ----
   // signals and instances
   // ----
   localparam logic [7:0] M_LLO = 8'h20, M_GTL = 8'h10, M_MLA = 8'h08, M_MTA = 8'h04;
   logic CLK = 1'b0, RSTN, ADDR_WE, AUTORANGE_EN, REL_EN, ZERO_CORR_EN;
   rl_pkg::bus_evt_t BUS_EVT;
   rl_pkg::lamps_t LAMPS;
   logic [4:0] ADDR_IN, PRIMARY_ADDR;
   logic [7:0] PANEL_KEYS, PANEL_KEYS_GATED;
   logic LOCKOUT, TALK_ACTIVE;
   logic [23:0] RAW_MAG, RANGE_LIMIT_0, RANGE_LIMIT_1, RANGE_LIMIT_2, RANGE_LIMIT_3;
   logic [2:0] MANUAL_RANGE, RANGE_SEL;
   logic signed [23:0] RAW_IN, ZERO_OFFSET, BASELINE, READING;
   int n_errors = 0, check_count = 0;
   logic [4:0] a_in[3] = '{5'h1E, 5'h1F, 5'h00};
   logic [4:0] a_exp[3] = '{5'h1E, 5'h1E, 5'h00};
   logic [23:0] mag[4] = '{24'h100, 24'h150, 24'h400, 24'h401};
   logic [2:0] r_exp[4] = '{3'h0, 3'h1, 3'h3, 3'h4};

   always #4 CLK = ~CLK;

   bus_ctrl_model bus_ctrl_model_inst (.clk(CLK), .evt(BUS_EVT));
   rl_control rl_control_inst (.CLK(CLK), .RSTN(RSTN), .BUS_EVT(BUS_EVT),
      .ADDR_WE(ADDR_WE), .ADDR_IN(ADDR_IN), .PRIMARY_ADDR(PRIMARY_ADDR),
      .PANEL_KEYS(PANEL_KEYS), .PANEL_KEYS_GATED(PANEL_KEYS_GATED), .LAMPS(LAMPS),
      .LOCKOUT(LOCKOUT), .TALK_ACTIVE(TALK_ACTIVE), .AUTORANGE_EN(AUTORANGE_EN),
      .RAW_MAG(RAW_MAG), .RANGE_LIMIT_0(RANGE_LIMIT_0), .RANGE_LIMIT_1(RANGE_LIMIT_1),
      .RANGE_LIMIT_2(RANGE_LIMIT_2), .RANGE_LIMIT_3(RANGE_LIMIT_3),
      .MANUAL_RANGE(MANUAL_RANGE), .RANGE_SEL(RANGE_SEL), .REL_EN(REL_EN),
      .ZERO_CORR_EN(ZERO_CORR_EN), .RAW_IN(RAW_IN), .ZERO_OFFSET(ZERO_OFFSET),
      .BASELINE(BASELINE), .READING(READING));

   // ----
   // helper tasks
   // ----
   // two edges so one-edge-late lamps have landed
   task wt;
      repeat (2) @(posedge CLK);
      #1;
   endtask
   // case inequality: an unknown never matches
   task chk(input logic [23:0] seen, input logic [23:0] exp);
      check_count++;
      if (seen !== exp) begin
         n_errors++;
         $display("BAD t=%0t seen %h exp %h", $time, seen, exp);
      end
   endtask
   task keys(input logic [7:0] k);
      @(posedge CLK);
      PANEL_KEYS <= k;
   endtask
   task end_sim;
      $display("checks %0d mismatches %0d", check_count, n_errors);
      if (n_errors == 0 && check_count > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask

   // ----
   // tests
   // ----
   initial begin
      RSTN = 1'b0; ADDR_WE = 1'b0; ADDR_IN = 5'h00; PANEL_KEYS = 8'hFE;
      AUTORANGE_EN = 1'b1; REL_EN = 1'b1; ZERO_CORR_EN = 1'b0; MANUAL_RANGE = 3'h0;
      RANGE_LIMIT_0 = 24'h100; RANGE_LIMIT_1 = 24'h200;
      RANGE_LIMIT_2 = 24'h300; RANGE_LIMIT_3 = 24'h400;
      RAW_MAG = 24'h0; RAW_IN = 24'h0; ZERO_OFFSET = 24'h5; BASELINE = 24'h300;
      repeat (2) @(posedge CLK);
      RSTN <= 1'b1;
      #1;
      chk(PRIMARY_ADDR, 24'h16);
      bus_ctrl_model_inst.pulse(M_MLA); wt; chk(LAMPS.remote, 24'h0);
      bus_ctrl_model_inst.set_ren(1'b1); wt; chk(LAMPS.remote, 24'h0);
      chk(PANEL_KEYS_GATED, 24'hFE);
      bus_ctrl_model_inst.pulse(M_MLA); wt; chk(LAMPS, 24'h5);
      chk(PANEL_KEYS_GATED, 24'h00);
      for (int i = 0; i < 2; i++) begin
         bus_ctrl_model_inst.pulse(i == 0 ? M_MTA : M_MLA); wt;
         chk(TALK_ACTIVE, i == 0 ? 24'h1 : 24'h0);
         bus_ctrl_model_inst.clear_bus; wt;
         chk({LAMPS.talk, LAMPS.listen, TALK_ACTIVE}, 24'h0);
      end
      keys(8'hFF); wt; chk(LAMPS.remote, 24'h0);
      chk(PANEL_KEYS_GATED, 24'hFF);
      keys(8'hFE); bus_ctrl_model_inst.pulse(M_MTA); wt; chk(TALK_ACTIVE, 24'h1);
      bus_ctrl_model_inst.pulse(8'h01); wt; chk(TALK_ACTIVE, 24'h0);
      bus_ctrl_model_inst.pulse(M_MLA); bus_ctrl_model_inst.pulse(M_LLO);
      keys(8'hFF); wt; chk(LOCKOUT, 24'h1);
      chk({LAMPS.remote, PANEL_KEYS_GATED}, 24'h100);
      keys(8'hFE); bus_ctrl_model_inst.pulse(M_GTL); wt;
      chk({LAMPS.remote, PANEL_KEYS_GATED}, 24'hFE);
      chk(LOCKOUT, 24'h1);
      // armed lockout: listen re-entry locks again and the local key stays dead
      bus_ctrl_model_inst.pulse(M_MLA); keys(8'hFF); wt;
      chk({LAMPS.remote, PANEL_KEYS_GATED}, 24'h100);
      keys(8'hFE);
      bus_ctrl_model_inst.set_ren(1'b0); wt; chk(LOCKOUT, 24'h0);
      bus_ctrl_model_inst.set_ren(1'b1); bus_ctrl_model_inst.pulse(M_MLA); wt;
      chk(LAMPS.remote, 24'h1);
      bus_ctrl_model_inst.set_ren(1'b0); wt; chk(LAMPS.remote, 24'h0);
      $display("test bus done");
      // out-of-range address must leave the old one
      foreach (a_in[i]) begin
         @(posedge CLK); ADDR_IN <= a_in[i]; ADDR_WE <= 1'b1;
         @(posedge CLK); ADDR_WE <= 1'b0;
         wt; chk(PRIMARY_ADDR, a_exp[i]);
      end
      $display("test addr done");
      // large baseline must not steer the range
      foreach (mag[i]) begin
         @(posedge CLK); RAW_MAG <= mag[i];
         wt; chk(RANGE_SEL, r_exp[i]);
      end
      @(posedge CLK); AUTORANGE_EN <= 1'b0; MANUAL_RANGE <= 3'h2; BASELINE <= 24'h7;
      RAW_IN <= 24'h5; ZERO_CORR_EN <= 1'b1;
      wt; chk(RANGE_SEL, 24'h2);
      chk(READING, 24'hFFFFF9);
      @(posedge CLK); RAW_IN <= 24'h14;
      wt; chk(READING, 24'h8);
      @(posedge CLK); ZERO_CORR_EN <= 1'b0;
      wt; chk(READING, 24'hD);
      $display("test meas done");
      end_sim;
   end

   // two full clears plus about a hundred cycles of traffic
   initial begin
      repeat (40000) @(posedge CLK);
      n_errors++;
      $display("BAD t=%0t watchdog expired", $time);
      end_sim;
   end
endmodule
`default_nettype wire
